// *** arf_ctl.sv ***
// Converter control: scan sequencer, result store, ready pin, status.
// Assumes the modulator/filter signals share ref_clk, the host reads
// results on link_clk, and address straps arrive from pins.
//
// Summary of operation
// - Ready pin only pulls low, open drain.
// - Modes one to three: low on stored result.
// - Release after readout unless usage interrupt pending.
// - Usage interrupt alone also holds pin low.
// - Mode four: pin shows comparison and usage.
// - Results buffered in a 64-entry store.
// - Modulator overrange reported as status flag.
// - Filter overflow reported as status flag.
// - Autoscan interrupts on out-of-range input or usage, not on stored data.
// - Scan channels, wake-up, delay, result math.
// - Scan, pin and status timing from the system clock; host readout on the link clock.
// - Six input pairs, direct or amplified.
// - Reset gives direct routing, amplifier off.
// - Bypass keeps the amplifier powered down.
// - Gain selectable from 1x to 128x.
// - Register bits close switches to ground.
module arf_ctl (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  input  wire logic                          link_clk,
  input  wire logic [arf_pkg::MODE_W-1:0]    seq_mode,
  input  wire logic                          seq_enable,
  input  wire logic [arf_pkg::CHAN_N-1:0]    scan_mask,
  input  wire logic [arf_pkg::DLY_W-1:0]     wake_period,
  input  wire logic [arf_pkg::DLY_W-1:0]     conv_delay,
  input  wire logic                          math_sub_en,
  input  wire logic [arf_pkg::DATA_W-1:0]    math_offset,
  input  wire logic [arf_pkg::DATA_W-1:0]    limit_lo,
  input  wire logic [arf_pkg::DATA_W-1:0]    limit_hi,
  input  wire logic                          usage_en,
  input  wire logic [arf_pkg::PTR_W-1:0]     usage_thresh,
  input  wire logic                          conv_done,
  input  wire logic [arf_pkg::DATA_W-1:0]    conv_data,
  input  wire logic                          mod_overrange,
  input  wire logic                          filt_overflow,
  input  wire logic                          status_clr,
  input  wire logic                          bypass_sel,
  input  wire logic                          pga_enable,
  input  wire logic [arf_pkg::GAIN_W-1:0]    gain_sel,
  input  wire logic [arf_pkg::CHAN_N-1:0]    switch_ctl,
  input  wire logic                          bus_addr_sel_0,
  input  wire logic                          bus_addr_sel_1,
  input  wire logic                          host_rd_req,
  output arf_pkg::arf_result_t               host_rd_data_q,
  output logic                               host_rd_valid_q,
  output logic                               host_empty_q,
  output logic                               ready_irq_n_o_q,
  output logic                               ready_irq_n_oe_q,
  output arf_pkg::arf_status_t               status_q,
  output logic                               conv_start_q,
  output logic [arf_pkg::CHAN_W-1:0]         chan_sel_q,
  output logic                               pga_route_q,
  output logic                               pga_power_q,
  output logic [arf_pkg::GAIN_W-1:0]         gain_q,
  output logic [arf_pkg::CHAN_N-1:0]         switch_out_q,
  output logic [1:0]                         bus_addr_q
);

  // Sequencer state and counters.
  arf_pkg::arf_seq_t              st_q, st_d;
  logic [arf_pkg::DLY_W-1:0]      wake_q, dly_q;
  logic [arf_pkg::CHAN_W-1:0]     next_chan;
  logic                           next_found;
  // Result path and store status.
  arf_pkg::arf_result_t           res;
  logic [arf_pkg::DATA_W-1:0]     math_data;
  logic                           push, st_ready;
  logic [arf_pkg::PTR_W-1:0]      level;
  logic                           store_nempty;
  logic                           rd_empty_l;
  // Ready pin terms.
  logic                           mode13, mode4, usage, out_rng;
  logic                           pin_req;
  logic                           wake_hit, start_ok;
  logic [1:0]                     addr_s;
  logic [arf_pkg::GAIN_W-1:0]     gain_clip;

  // Address straps come from pins, so they are synchronised first.
  arf_sync #(.W(2)) u_addr (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({bus_addr_sel_1, bus_addr_sel_0}),
    .q   (addr_s)
  );

  // Finds the lowest enabled channel above the current one, or the lowest enabled of all when idle.
  always_comb begin
    next_chan  = '0;
    next_found = 1'b0;
    for (int i = arf_pkg::CHAN_N - 1; i >= 0; i--) begin
      if (scan_mask[i] && (i > int'(chan_sel_q) || st_q == arf_pkg::SEQ_IDLE))
      begin
        next_chan  = arf_pkg::CHAN_W'(i);
        next_found = 1'b1;
      end
    end
  end

  assign math_data = math_sub_en ? conv_data - math_offset : conv_data;
  assign res       = '{chan: chan_sel_q, data: math_data};
  assign out_rng   = ($signed(math_data) < $signed(limit_lo)) ||
                     ($signed(math_data) > $signed(limit_hi));
  assign push      = st_q == arf_pkg::SEQ_CONV && conv_done;
  assign mode13    = seq_mode >= arf_pkg::MODE_1 &&
                     seq_mode <= arf_pkg::MODE_3;
  assign mode4     = seq_mode == arf_pkg::MODE_4;
  assign usage     = usage_en && level >= usage_thresh;
  assign store_nempty = level != '0;
  assign pin_req   = (mode13 && store_nempty) ||
                     (mode4 && status_q.out_of_range) || usage;
  assign wake_hit  = wake_q == '0;
  // A full store stalls the next conversion.
  assign start_ok  = seq_enable && st_ready && next_found;
  assign gain_clip = gain_sel > arf_pkg::GAIN_MAX ? arf_pkg::GAIN_MAX
                                                  : gain_sel;

  arf_rfifo u_store (
    .wr_clk     (ref_clk),
    .wr_ce      (clk_en),
    .rst        (sys_rst),
    .wr_valid   (push),
    .wr_data    (res),
    .wr_ready   (st_ready),
    .wr_level   (level),
    .rd_clk     (link_clk),
    .rd_req     (host_rd_req),
    .rd_data_q  (host_rd_data_q),
    .rd_valid_q (host_rd_valid_q),
    .rd_empty   (rd_empty_l)
  );

  // Link-side empty flag, registered for the host.
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_empty_q <= 1'b1;
    end else begin
      host_empty_q <= rd_empty_l;
    end
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      // Waits for the wake-up count, then starts a scan.
      arf_pkg::SEQ_IDLE: begin
        if (wake_hit && start_ok) begin
          st_d = arf_pkg::SEQ_DELAY;
        end
      end
      // Programmable settling delay before each conversion.
      arf_pkg::SEQ_DELAY: begin
        if (dly_q == '0 && st_ready) begin
          st_d = arf_pkg::SEQ_CONV;
        end
      end
      // Waits for the filter to deliver a result.
      arf_pkg::SEQ_CONV: begin
        if (conv_done) begin
          st_d = arf_pkg::SEQ_NEXT;
        end
      end
      // Moves to the next enabled channel or ends the scan.
      arf_pkg::SEQ_NEXT: begin
        st_d = next_found && seq_enable ? arf_pkg::SEQ_DELAY
                                        : arf_pkg::SEQ_IDLE;
      end
      default: st_d = arf_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q  <= arf_pkg::SEQ_IDLE;
      wake_q <= '0;
      dly_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      if (st_q != arf_pkg::SEQ_IDLE || wake_hit) begin
        wake_q <= wake_period;
      end else begin
        wake_q <= wake_q - 1'b1;
      end
      if (st_d == arf_pkg::SEQ_DELAY && st_q != arf_pkg::SEQ_DELAY) begin
        dly_q <= conv_delay;
      end else if (dly_q != '0) begin
        dly_q <= dly_q - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_sel_q   <= '0;
      conv_start_q <= 1'b0;
    end else if (clk_en) begin
      conv_start_q <= st_q == arf_pkg::SEQ_DELAY &&
                      st_d == arf_pkg::SEQ_CONV;
      if (st_d == arf_pkg::SEQ_DELAY && st_q != arf_pkg::SEQ_DELAY) begin
        chan_sel_q <= next_chan;
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= '0;
    end else if (clk_en) begin
      status_q.overrange <= mod_overrange ||
                            (status_q.overrange && !status_clr);
      status_q.overflow <= filt_overflow ||
                           (status_q.overflow && !status_clr);
      status_q.out_of_range <= (push && mode4 && out_rng) ||
                               (status_q.out_of_range && !status_clr);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_irq_n_o_q  <= 1'b0;
      ready_irq_n_oe_q <= 1'b0;
    end else if (clk_en) begin
      ready_irq_n_o_q  <= 1'b0;
      ready_irq_n_oe_q <= pin_req;
    end
  end

  // Analog controls: routing, amplifier power, gain, switches.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pga_route_q  <= !arf_pkg::BYPASS_RST;
      pga_power_q  <= 1'b0;
      gain_q       <= arf_pkg::GAIN_MIN;
      switch_out_q <= '0;
      bus_addr_q   <= '0;
    end else if (clk_en) begin
      pga_route_q  <= !bypass_sel;
      pga_power_q  <= pga_enable && !bypass_sel;
      gain_q       <= gain_clip;
      switch_out_q <= switch_ctl;
      bus_addr_q   <= addr_s;
    end
  end

  // Ready pin is driven low whenever a result waits in modes 1-3.
  ready_data_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode13 && store_nempty |=> ready_irq_n_oe_q)
    else $error("ready pin not pulled for stored result");

  // Pin is released once the store is drained and no usage alarm.
  ready_release_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode13 && !store_nempty && !usage
    |=> !ready_irq_n_oe_q)
    else $error("ready pin held after store drained");

  // Usage alarm holds the pin low regardless of mode.
  usage_hold_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && usage |=> ready_irq_n_oe_q)
    else $error("usage alarm did not pull ready pin");

  // In autoscan, stored data alone never pulls the pin.
  scan_quiet_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && mode4 && !status_q.out_of_range && !usage
    |=> !ready_irq_n_oe_q)
    else $error("ready pin pulled in autoscan without cause");

  // The pin data is never high: the line is only pulled or released.
  drain_only_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    ready_irq_n_o_q == 1'b0)
    else $error("ready pin driven high");

  // Overrange is captured and held until cleared.
  overrange_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && mod_overrange ##1 (!clk_en || !status_clr)[*2]
    |-> status_q.overrange)
    else $error("overrange flag lost");

  // Overflow flag survives while no clear is given.
  overflow_hold_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && status_q.overflow && !status_clr |=> status_q.overflow)
    else $error("overflow flag dropped without clear");

  // Bypass keeps the amplifier off.
  pga_off_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && bypass_sel |=> !pga_power_q && !pga_route_q)
    else $error("amplifier powered in bypass");

  // Conversion start is a single-cycle pulse.
  start_pulse_a : assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && conv_start_q |=> !conv_start_q)
    else $error("conversion start longer than one cycle");

endmodule : arf_ctl

// *** arf_host_model.sv ***
// Host reader model that pops results from the store on the link clock.
// Assumes the store ignores a pop made while it reads empty.
module arf_host_model (
  input  wire logic link_clk,
  input  wire logic sys_rst,
  input  wire logic rd_en,
  input  wire logic host_empty_q,
  output logic      host_rd_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pops every other link cycle while allowed and not empty.
  // host readout
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_rd_req <= 1'b0;
    end else begin
      host_rd_req <= !host_rd_req && rd_en && !host_empty_q;
    end
  end
endmodule : arf_host_model

// *** arf_pkg.sv ***
// Shared constants and types for the converter control block.
// Assumes one system clock domain and one link clock domain.
package arf_pkg;

  // Width of one conversion result.
  localparam int DATA_W = 24;
  // Result store depth and its pointer width.
  localparam int FIFO_DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int PTR_W = ADDR_W + 1;
  // Six differential input pairs, selected by a three-bit code.
  localparam int CHAN_N = 6;
  localparam int CHAN_W = 3;
  // Eight gain steps, code 0 is 1x and code 7 is 128x.
  localparam int GAIN_W = 3;
  localparam logic [GAIN_W-1:0] GAIN_MIN = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 3'h7;
  // Sequencer mode codes.
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_1 = 3'h1;
  localparam logic [MODE_W-1:0] MODE_3 = 3'h3;
  localparam logic [MODE_W-1:0] MODE_4 = 3'h4;
  // Widths of the wake-up and pre-conversion delay counters.
  localparam int DLY_W = 16;
  // Nominal system clock of the converter core, in hertz.
  localparam int SYSCLK_HZ = 8192000;
  // Reset value of the input routing: direct connect.
  localparam logic BYPASS_RST = 1'b1;

  // One stored conversion result with the channel it came from.
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } arf_result_t;

  // Sticky status flags.
  typedef struct packed {
    logic overrange;
    logic overflow;
    logic out_of_range;
  } arf_status_t;

  // Scan sequencer states, one-hot.
  typedef enum logic [3:0] {
    SEQ_IDLE  = 4'b0001,
    SEQ_DELAY = 4'b0010,
    SEQ_CONV  = 4'b0100,
    SEQ_NEXT  = 4'b1000
  } arf_seq_t;

endpackage : arf_pkg

// *** arf_rfifo.sv ***
// Result store crossing from the system clock to the link clock.
// Assumes the writer honours wr_ready and the reader pulses rd_req.
module arf_rfifo (
  input  wire logic                      wr_clk,
  input  wire logic                      wr_ce,
  input  wire logic                      rst,
  input  wire logic                      wr_valid,
  input  wire arf_pkg::arf_result_t      wr_data,
  output logic                           wr_ready,
  output logic [arf_pkg::PTR_W-1:0]      wr_level,
  input  wire logic                      rd_clk,
  input  wire logic                      rd_req,
  output arf_pkg::arf_result_t           rd_data_q,
  output logic                           rd_valid_q,
  output logic                           rd_empty
);

  localparam int PW = arf_pkg::PTR_W;

  // Storage array, written on the system side only.
  arf_pkg::arf_result_t mem [arf_pkg::FIFO_DEPTH];
  logic [PW-1:0] wbin_q, wgray_q, rbin_q, rgray_q;
  // Gray pointers after crossing into the other domain.
  logic [PW-1:0] rgray_s, wgray_s;
  logic [PW-1:0] wbin_d, rbin_d, rbin_s;
  logic          push, pop;

  // Converts a gray code back to binary.
  function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction : g2b

  // Full when the write pointer is one lap ahead of the read pointer.
  assign wr_ready = wgray_q != {~rgray_s[PW-1:PW-2], rgray_s[PW-3:0]};
  assign push     = wr_ce && wr_valid && wr_ready;
  assign wbin_d   = wbin_q + 1'b1;
  assign rbin_s   = g2b(rgray_s);
  assign wr_level = wbin_q - rbin_s;
  assign rd_empty = rgray_q == wgray_s;
  assign pop      = rd_req && !rd_empty;
  assign rbin_d   = rbin_q + 1'b1;

  // Pointer crossings.
  arf_sync #(.W(PW)) u_rsync (.clk(wr_clk), .rst(rst), .d(rgray_q),
                              .q(rgray_s));
  arf_sync #(.W(PW)) u_wsync (.clk(rd_clk), .rst(rst), .d(wgray_q),
                              .q(wgray_s));

  // Write pointer advances on each accepted result.
  always_ff @(posedge wr_clk or posedge rst) begin
    if (rst) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else if (push) begin
      wbin_q  <= wbin_d;
      wgray_q <= wbin_d ^ (wbin_d >> 1);
    end
  end

  // The array itself carries no reset.
  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_q[arf_pkg::ADDR_W-1:0]] <= wr_data;
    end
  end

  // Read side: one entry per request, valid for one link cycle.
  always_ff @(posedge rd_clk or posedge rst) begin
    if (rst) begin
      rbin_q     <= '0;
      rgray_q    <= '0;
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
    end else begin
      rd_valid_q <= pop;
      if (pop) begin
        rd_data_q <= mem[rbin_q[arf_pkg::ADDR_W-1:0]];
        rbin_q    <= rbin_d;
        rgray_q   <= rbin_d ^ (rbin_d >> 1);
      end
    end
  end

endmodule : arf_rfifo

// *** arf_sync.sv ***
// Two-flop level synchroniser, any width.
// Assumes the input changes no faster than the destination can see.
module arf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // First stage, read only by the second stage.
  logic [W-1:0] meta_q;

  // Both stages clear to zero on reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : arf_sync

// *** tb_adc_result_fifo_ready_irq.sv ***
// Bench for the converter control block: scan, store, ready pin, status.
// Assumes arf_pkg, arf_ctl and arf_host_model are compiled before it.
module tb_adc_result_fifo_ready_irq;
  timeunit 1ns;
  timeprecision 1ps;

  // Drive delay after each rising edge.
  localparam time TD = 1ns;
  logic                       ref_clk, link_clk, sys_rst, clk_en, rd_en;
  logic                       seq_enable, math_sub_en, usage_en, conv_done;
  logic                       mod_overrange, filt_overflow, status_clr;
  logic                       bypass_sel, pga_enable, host_rd_req;
  logic                       bus_addr_sel_0, bus_addr_sel_1;
  logic [arf_pkg::MODE_W-1:0] seq_mode;
  logic [arf_pkg::CHAN_N-1:0] scan_mask, switch_ctl, switch_out_q;
  logic [arf_pkg::DLY_W-1:0]  wake_period, conv_delay;
  logic [arf_pkg::DATA_W-1:0] math_offset, limit_lo, limit_hi, conv_data;
  logic [arf_pkg::PTR_W-1:0]  usage_thresh;
  logic [arf_pkg::GAIN_W-1:0] gain_sel, gain_q;
  logic [arf_pkg::CHAN_W-1:0] chan_sel_q;
  logic [1:0]                 bus_addr_q;
  logic                       host_rd_valid_q, host_empty_q, conv_start_q;
  logic                       ready_irq_n_o_q, ready_irq_n_oe_q;
  logic                       pga_route_q, pga_power_q;
  arf_pkg::arf_result_t       host_rd_data_q;
  arf_pkg::arf_status_t       status_q;
  arf_pkg::arf_result_t       exp_q[$];
  int                         check_count, n_mismatch, seed;
  wire                        ready_irq_n;

  // The pin has a pull-up, so it reads high whenever it is released.
  assign ready_irq_n = ready_irq_n_oe_q ? ready_irq_n_o_q : 1'b1;

  arf_ctl dut (
    .ref_clk, .sys_rst, .clk_en, .link_clk, .seq_mode, .seq_enable,
    .scan_mask, .wake_period, .conv_delay, .math_sub_en, .math_offset,
    .limit_lo, .limit_hi, .usage_en, .usage_thresh, .conv_done, .conv_data,
    .mod_overrange, .filt_overflow, .status_clr, .bypass_sel, .pga_enable,
    .gain_sel, .switch_ctl, .bus_addr_sel_0, .bus_addr_sel_1, .host_rd_req,
    .host_rd_data_q, .host_rd_valid_q, .host_empty_q, .ready_irq_n_o_q,
    .ready_irq_n_oe_q, .status_q, .conv_start_q, .chan_sel_q, .pga_route_q,
    .pga_power_q, .gain_q, .switch_out_q, .bus_addr_q
  );

  arf_host_model host (.link_clk, .sys_rst, .rd_en, .host_empty_q,
                       .host_rd_req);

  // System clock of 8 ns and an unrelated link clock of 64 ns.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    // Offset keeps link edges clear of the bench's drive instants.
    #11;
    forever #32 link_clk = ~link_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic give_up();
    n_mismatch++;
    $display("BAD %0t wait ran out", $time);
    wrap_up();
  endtask : give_up

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #TD;
  endtask : tick

  // Waits a bounded time for the pin level, then compares it.
  task automatic wait_pin(input logic v);
    for (int i = 0; i < 50 && ready_irq_n !== v; i++) tick(1);
    check(32'(ready_irq_n), 32'(v));
    // A wait that ran out has been counted; close the run here.
    if (ready_irq_n !== v) wrap_up();
  endtask : wait_pin

  // Scans one channel, answers the conversion and notes the result.
  task automatic convert(input int c, input logic [23:0] raw,
                         input logic pin_exp);
    arf_pkg::arf_result_t e;
    int i;
    e.chan = 3'(c);
    e.data = math_sub_en ? raw - math_offset : raw;
    scan_mask = 6'(1 << c);
    seq_enable = 1'b1;
    for (i = 0; i < 400 && conv_start_q !== 1'b1; i++) tick(1);
    if (i == 400) give_up();
    check(32'(chan_sel_q), 32'(c));
    tick(1);
    conv_done = 1'b1;
    conv_data = raw;
    tick(1);
    conv_done = 1'b0;
    seq_enable = 1'b0;
    exp_q.push_back(e);
    tick(4);
    check(32'(ready_irq_n), 32'(pin_exp));
  endtask : convert

  // Lets the host read until every noted result came back.
  task automatic drain();
    int i;
    rd_en = 1'b1;
    for (i = 0; i < 3000; i++) begin
      if (exp_q.size() == 0 && host_empty_q === 1'b1) break;
      tick(1);
    end
    if (i == 3000) give_up();
    rd_en = 1'b0;
  endtask : drain

  // Each result read by the host is compared with the oldest note.
  always @(negedge link_clk) begin
    if (host_rd_valid_q === 1'b1) begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(32'(host_rd_data_q), 32'(exp_q.pop_front()));
    end
  end

  // The pin data must be low whenever the pin is pulled.
  always @(negedge ref_clk) begin
    if (ready_irq_n_oe_q === 1'b1) check(32'(ready_irq_n_o_q), 32'h0);
  end

  initial begin
    int n;
    seed = 82007;
    {sys_rst, clk_en, bypass_sel, math_sub_en} = 4'h7;
    {rd_en, seq_enable, usage_en, conv_done, pga_enable} = 5'h00;
    {mod_overrange, filt_overflow, status_clr} = 3'h0;
    {bus_addr_sel_0, bus_addr_sel_1, gain_sel} = 5'h00;
    {scan_mask, switch_ctl, conv_data} = 36'h0_0000_0000;
    seq_mode = arf_pkg::MODE_1;
    wake_period = 16'h0004;
    conv_delay = 16'h0003;
    math_offset = 24'h00_0100;
    limit_lo = 24'hFF_FF9C;
    limit_hi = 24'h00_0064;
    usage_thresh = 7'h02;
    // A clean rising edge of reset clears both clock domains at once,
    // even before the slow link clock has ticked.
    #TD;
    sys_rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #TD;
    sys_rst = 1'b0;
    tick(20);
    check(32'({pga_route_q, pga_power_q, host_empty_q, ready_irq_n}),
          32'h3);
    // Every gain code, with random routing, switches and straps.
    for (int g = 0; g < 8; g++) begin
      gain_sel = 3'(g);
      switch_ctl = 6'($random(seed));
      {bypass_sel, pga_enable, bus_addr_sel_1, bus_addr_sel_0} =
        4'($random(seed));
      tick(4);
      check(32'(gain_q), 32'(g));
      check(32'(switch_out_q), 32'(switch_ctl));
      check(32'({pga_route_q, pga_power_q}),
            32'({!bypass_sel, !bypass_sel && pga_enable}));
      check(32'(bus_addr_q), 32'({bus_addr_sel_1, bus_addr_sel_0}));
    end
    // Fill the store, then no further conversion may start.
    for (int k = 0; k < arf_pkg::FIFO_DEPTH; k++)
      convert(k % 6, 24'($random(seed)), 1'b0);
    n = 0;
    seq_enable = 1'b1;
    repeat (300) begin
      tick(1);
      if (conv_start_q === 1'b1) n++;
    end
    seq_enable = 1'b0;
    check(32'(n), 32'h0);
    drain();
    wait_pin(1'b1);
    // A usage alarm alone holds the pin low.
    usage_en = 1'b1;
    usage_thresh = 7'h00;
    wait_pin(1'b0);
    usage_en = 1'b0;
    wait_pin(1'b1);
    for (int m = 2; m < 4; m++) begin
      seq_mode = 3'(m);
      convert(m, 24'($random(seed)), 1'b0);
      drain();
      wait_pin(1'b1);
    end
    // Status flags, with an event winning over a clear.
    mod_overrange = 1'b1;
    tick(1);
    mod_overrange = 1'b0;
    check(32'(status_q), 32'h4);
    filt_overflow = 1'b1;
    tick(1);
    filt_overflow = 1'b0;
    check(32'(status_q), 32'h6);
    {status_clr, mod_overrange} = 2'h3;
    tick(1);
    {status_clr, mod_overrange} = 2'h0;
    check(32'(status_q), 32'h4);
    status_clr = 1'b1;
    tick(1);
    status_clr = 1'b0;
    check(32'(status_q), 32'h0);
    // Clock enable low freezes status and settings against new events.
    clk_en = 1'b0;
    filt_overflow = 1'b1;
    gain_sel = 3'h2;
    tick(3);
    check(32'({status_q, gain_q}), 32'({3'h0, arf_pkg::GAIN_MAX}));
    {clk_en, filt_overflow} = 2'h2;
    // Autoscan: usage threshold boundary, then limits on both sides.
    seq_mode = arf_pkg::MODE_4;
    math_sub_en = 1'b0;
    usage_en = 1'b1;
    usage_thresh = 7'h02;
    convert(0, 24'h00_0032, 1'b1);
    convert(5, 24'hFF_FFCE, 1'b0);
    drain();
    wait_pin(1'b1);
    usage_en = 1'b0;
    for (int j = 0; j < 2; j++) begin
      convert(j + 1, j ? 24'hFF_FE00 : 24'h00_01F4, 1'b0);
      check(32'(status_q), 32'h1);
      status_clr = 1'b1;
      tick(1);
      status_clr = 1'b0;
      wait_pin(1'b1);
    end
    drain();
    wrap_up();
  end
endmodule : tb_adc_result_fifo_ready_irq
